/* pwsft_map.vh */
// Timing and encoding constants for the power switch fault timing block.
`ifndef PWSFT_MAP_VH
`define PWSFT_MAP_VH
`define PWSFT_CLK_HZ        100000000
`define PWSFT_BLANK_MS      32
`define PWSFT_OFF_MS        128
`define PWSFT_SURGE_MS      128
`define PWSFT_LOCK_MS       128
`define PWSFT_CYC_PER_MS    (`PWSFT_CLK_HZ / 1000)
`define PWSFT_BLANK_CYC     (`PWSFT_BLANK_MS * `PWSFT_CYC_PER_MS)
`define PWSFT_OFF_CYC       (`PWSFT_OFF_MS * `PWSFT_CYC_PER_MS)
`define PWSFT_SURGE_CYC     (`PWSFT_SURGE_MS * `PWSFT_CYC_PER_MS)
`define PWSFT_LOCK_CYC      (`PWSFT_LOCK_MS * `PWSFT_CYC_PER_MS)
`define PWSFT_CNT_W         24
`define PWSFT_CNT_ZERO      24'h000000
`define PWSFT_CNT_ONE       24'h000001
`define PWSFT_ST_W          2
`define PWSFT_UV_RUN        2'h0
`define PWSFT_UV_OFF        2'h1
`define PWSFT_SG_IDLE       2'h0
`define PWSFT_SG_WIN        2'h1
`define PWSFT_SG_LIMIT      2'h2
`define PWSFT_SG_LOCK       2'h3
`endif

/* pwsft_timer.v */
// Cycle down-counter that flags expiry of a loaded interval.
`timescale 1ns/1ps
module pwsft_timer #(
  parameter                  W = 24
) (
  input  wire                ref_clk_in,
  input  wire                clear_in,
  input  wire                start_in,
  input  wire [W-1:0]        load_in,
  output wire                done_out,
  output wire                busy_out
);
  reg    [W-1:0]             cnt_ff;
  reg    [W-1:0]             nxt_cnt;
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (clear_in)
      nxt_cnt = {W{1'b0}};
    else if (start_in)
      nxt_cnt = load_in;
    else if (cnt_ff != {W{1'b0}})
      nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
  end
  always @(posedge ref_clk_in)
  begin
    cnt_ff <= nxt_cnt;
  end
  assign done_out = (cnt_ff == {{(W-1){1'b0}}, 1'b1}) && !clear_in && !start_in;
  assign busy_out = (cnt_ff != {W{1'b0}});
endmodule

/* pwsft_uv_seq.v */
// Undervoltage blanking and retry sequencer.
`timescale 1ns/1ps
`include "pwsft_map.vh"
module pwsft_uv_seq #(
  parameter                  BLANK_CYC = `PWSFT_BLANK_CYC,
  parameter                  OFF_CYC   = `PWSFT_OFF_CYC
) (
  input  wire                ref_clk_in,
  input  wire                reset_in,
  input  wire                uv_below_in,
  output wire                uv_allow_out,
  output wire                uv_trip_out
);
  localparam [`PWSFT_CNT_W-1:0] BLANK_LD = BLANK_CYC[`PWSFT_CNT_W-1:0];
  localparam [`PWSFT_CNT_W-1:0] OFF_LD   = OFF_CYC[`PWSFT_CNT_W-1:0];
  reg    [`PWSFT_ST_W-1:0]   state_ff;
  reg    [`PWSFT_ST_W-1:0]   nxt_state;
  wire                       blank_done;
  wire                       blank_busy;
  wire                       off_done;
  wire                       blank_start;
  wire                       blank_clr;
  // Raw comparator level is used with no hysteresis; only the blanking timer filters chatter.
  assign blank_start = (state_ff == `PWSFT_UV_RUN) && uv_below_in && !blank_busy;
  // Any rise above trip restarts the blanking interval from zero.
  assign blank_clr   = reset_in || !uv_below_in || (state_ff != `PWSFT_UV_RUN);
  pwsft_timer #(.W(`PWSFT_CNT_W)) u_blank (
    .ref_clk_in (ref_clk_in),
    .clear_in   (blank_clr),
    .start_in   (blank_start),
    .load_in    (BLANK_LD),
    .done_out   (blank_done),
    .busy_out   (blank_busy)
  );
  pwsft_timer #(.W(`PWSFT_CNT_W)) u_off (
    .ref_clk_in (ref_clk_in),
    .clear_in   (reset_in),
    .start_in   (state_ff == `PWSFT_UV_RUN && blank_done),
    .load_in    (OFF_LD),
    .done_out   (off_done),
    .busy_out   ()
  );
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `PWSFT_UV_RUN:
        if (blank_done)
          nxt_state = `PWSFT_UV_OFF;
      `PWSFT_UV_OFF:
        if (off_done)
          nxt_state = `PWSFT_UV_RUN;
      default:
        nxt_state = `PWSFT_UV_RUN;
    endcase
  end
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state_ff <= `PWSFT_UV_RUN;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end
  // Switch starts off out of reset while below trip; it then waits for a rise or a retry.
  reg                        boot_hold_ff;
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
      boot_hold_ff <= 1'b1;
    else if (!uv_below_in || blank_done)
      boot_hold_ff <= 1'b0;
  end
  // The raw level is used so the switch cannot pulse on in the first cycle after reset.
  assign uv_allow_out = (state_ff == `PWSFT_UV_RUN) && !(boot_hold_ff && uv_below_in);
  assign uv_trip_out  = (state_ff == `PWSFT_UV_RUN) && blank_done;
endmodule

/* pwsft_top.v */
// Fault timing top: undervoltage sequencer, surge-allowance control and thermal override.
`timescale 1ns/1ps
`include "pwsft_map.vh"
// Summary of operation
// - Disengage after unbroken 32 ms below trip.
// - After disengage, off 128 ms then on.
// - Still below trip: on 32 ms, repeat.
// - Above trip on retry: stay on.
// - Rising above trip restarts blanking timer.
// - Undervoltage input used without hysteresis.
// - Undervoltage and surge run independently.
// - Surge window allows secondary limit 128 ms.
// - Secondary limit flag acts at once.
// - After window, primary limit while overloaded.
// - Leaving limiting starts 128 ms lock-out.
// - Thermal shutdown ends window, switch off.
// - After thermal, resume at primary limit.
// - Thermal checked continuously, forces switch off.
module pwsft_top #(
  parameter                  BLANK_CYC = `PWSFT_BLANK_CYC,
  parameter                  OFF_CYC   = `PWSFT_OFF_CYC,
  parameter                  SURGE_CYC = `PWSFT_SURGE_CYC,
  parameter                  LOCK_CYC  = `PWSFT_LOCK_CYC
) (
  input  wire                ref_clk_in,
  input  wire                reset_in,
  input  wire                variable_undervoltage_lockout_in,
  input  wire                current_limit_in,
  input  wire                secondary_current_limit_in,
  input  wire                thermal_shutdown_in,
  output reg                 switch_enable_out,
  output reg                 secondary_limit_select_out,
  output reg                 secondary_clamp_out,
  output reg                 surge_active_out,
  output reg                 lockout_active_out,
  output reg                 uv_disengaged_out
);
  localparam [`PWSFT_CNT_W-1:0] SURGE_LD = SURGE_CYC[`PWSFT_CNT_W-1:0];
  localparam [`PWSFT_CNT_W-1:0] LOCK_LD  = LOCK_CYC[`PWSFT_CNT_W-1:0];
  wire                       uv_allow;
  wire                       surge_done;
  wire                       lock_done;
  reg    [`PWSFT_ST_W-1:0]   sg_state_ff;
  reg    [`PWSFT_ST_W-1:0]   nxt_sg_state;
  reg                        limit_q_ff;
  reg                        surge_start;
  reg                        lock_start;
  // Separate instance with its own timers, so a surge never delays undervoltage action.
  pwsft_uv_seq #(.BLANK_CYC(BLANK_CYC), .OFF_CYC(OFF_CYC)) u_uv (
    .ref_clk_in   (ref_clk_in),
    .reset_in     (reset_in),
    .uv_below_in  (variable_undervoltage_lockout_in),
    .uv_allow_out (uv_allow),
    .uv_trip_out  ()
  );
  pwsft_timer #(.W(`PWSFT_CNT_W)) u_surge (
    .ref_clk_in (ref_clk_in),
    .clear_in   (reset_in || thermal_shutdown_in),
    .start_in   (surge_start),
    .load_in    (SURGE_LD),
    .done_out   (surge_done),
    .busy_out   ()
  );
  pwsft_timer #(.W(`PWSFT_CNT_W)) u_lock (
    .ref_clk_in (ref_clk_in),
    .clear_in   (reset_in),
    .start_in   (lock_start),
    .load_in    (LOCK_LD),
    .done_out   (lock_done),
    .busy_out   ()
  );
  always @*
  begin
    nxt_sg_state = sg_state_ff;
    surge_start  = 1'b0;
    lock_start   = 1'b0;
    case (sg_state_ff)
      `PWSFT_SG_IDLE:
        if (current_limit_in && !limit_q_ff && !thermal_shutdown_in)
        begin
          nxt_sg_state = `PWSFT_SG_WIN;
          surge_start  = 1'b1;
        end
        else if (current_limit_in && !thermal_shutdown_in)
          nxt_sg_state = `PWSFT_SG_LIMIT;
      `PWSFT_SG_WIN:
        if (thermal_shutdown_in)
          nxt_sg_state = `PWSFT_SG_LIMIT;
        else if (surge_done)
          nxt_sg_state = `PWSFT_SG_LIMIT;
        else if (!current_limit_in)
        begin
          nxt_sg_state = `PWSFT_SG_LOCK;
          lock_start   = 1'b1;
        end
      `PWSFT_SG_LIMIT:
        if (!current_limit_in && !thermal_shutdown_in)
        begin
          nxt_sg_state = `PWSFT_SG_LOCK;
          lock_start   = 1'b1;
        end
      `PWSFT_SG_LOCK:
        if (current_limit_in)
        begin
          nxt_sg_state = `PWSFT_SG_LIMIT;
        end
        else if (lock_done)
          nxt_sg_state = `PWSFT_SG_IDLE;
      default:
        nxt_sg_state = `PWSFT_SG_IDLE;
    endcase
  end
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      sg_state_ff                <= `PWSFT_SG_IDLE;
      limit_q_ff                 <= 1'b0;
      switch_enable_out          <= 1'b0;
      secondary_limit_select_out <= 1'b0;
      secondary_clamp_out        <= 1'b0;
      surge_active_out           <= 1'b0;
      lockout_active_out         <= 1'b0;
      uv_disengaged_out          <= 1'b0;
    end
    else
    begin
      sg_state_ff                <= nxt_sg_state;
      limit_q_ff                 <= current_limit_in;
      // Thermal wins over every timer; the switch drops regardless of window or sequencer.
      switch_enable_out          <= uv_allow && !thermal_shutdown_in;
      // Primary limit is selected whenever the window is not running.
      secondary_limit_select_out <= (nxt_sg_state == `PWSFT_SG_WIN);
      // Clamp flag is passed through with no dependency on window state.
      secondary_clamp_out        <= secondary_current_limit_in;
      surge_active_out           <= (nxt_sg_state == `PWSFT_SG_WIN);
      lockout_active_out         <= (nxt_sg_state == `PWSFT_SG_LOCK);
      uv_disengaged_out          <= !uv_allow;
    end
  end
endmodule

/* pwsft_monitor.sv */
// Assertion checker watching the ports of the fault timing top.
`timescale 1ns/1ps
module pwsft_monitor #(
  parameter BLANK_CYC = 20
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic variable_undervoltage_lockout_in,
  input wire logic current_limit_in,
  input wire logic secondary_current_limit_in,
  input wire logic thermal_shutdown_in,
  input wire logic switch_enable_out,
  input wire logic secondary_limit_select_out,
  input wire logic secondary_clamp_out,
  input wire logic surge_active_out,
  input wire logic lockout_active_out,
  input wire logic uv_disengaged_out
);
  logic [23:0] below_ff;
  // Counts unbroken below-trip cycles; any upward crossing restarts it.
  always @(posedge ref_clk_in)
  begin
    below_ff <= (reset_in || !variable_undervoltage_lockout_in) ? 24'h0 : below_ff + 24'h1;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_onset;
    $rose(current_limit_in) && !lockout_active_out && !secondary_limit_select_out
      && !thermal_shutdown_in;
  endsequence
  sequence s_held;
    current_limit_in && $past(current_limit_in) && !secondary_limit_select_out;
  endsequence
  a_window_start: assert property (s_onset |=> secondary_limit_select_out)
    else $error("surge window did not open");
  a_no_regrant: assert property (s_held |=> !secondary_limit_select_out)
    else $error("surge window granted during held overload");
  a_lockout_blocks: assert property (
    lockout_active_out |=> !secondary_limit_select_out)
    else $error("surge window granted in lock-out");
  a_thermal_off: assert property (thermal_shutdown_in |=> !switch_enable_out)
    else $error("switch on during overtemperature");
  a_thermal_window: assert property (
    thermal_shutdown_in |=> !secondary_limit_select_out)
    else $error("surge window kept during overtemperature");
  a_clamp_prompt: assert property (
    secondary_current_limit_in |=> secondary_clamp_out)
    else $error("secondary clamp late");
  a_surge_mirror: assert property (
    surge_active_out == secondary_limit_select_out)
    else $error("surge flag differs from limit select");
  a_blank_unbroken: assert property (
    $fell(switch_enable_out) && !$past(thermal_shutdown_in) |-> below_ff >= BLANK_CYC - 2)
    else $error("load dropped before full blanking");
  a_boot_off: assert property (
    $past(reset_in) && variable_undervoltage_lockout_in |=> !switch_enable_out)
    else $error("switch on out of reset while below trip");
endmodule

/* pwsft_load_model.sv */
// Behavioural load and comparator model facing the switch outputs.
`timescale 1ns/1ps
module pwsft_load_model (
  input  wire logic ref_clk_in,
  input  wire logic switch_enable_in,
  input  wire logic overload_in,
  input  wire logic short_in,
  output logic      current_limit_out,
  output logic      secondary_limit_out
);
  initial
  begin
    current_limit_out = 1'h0;
    secondary_limit_out = 1'h0;
  end
  // A load can only pull limit current while the pass transistor conducts.
  always @(negedge ref_clk_in)
  begin
    current_limit_out <= switch_enable_in && overload_in;
    secondary_limit_out <= switch_enable_in && short_in;
  end
endmodule

/* pwsft_bench.sv */
// Self-checking bench for the power switch fault timing block.
`timescale 1ns/1ps
module pwsft_bench;
  localparam BL = 20, OF = 50, SU = 40, LO = 40;
  logic clk = 1'h0, rst = 1'h1, uv = 1'h1, ovl = 1'h0, sht = 1'h0, th = 1'h0;
  wire  cl, sc, sw, sel, clmp, lk, sa, dis;
  int   n_mismatch = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  pwsft_top #(.BLANK_CYC(BL), .OFF_CYC(OF), .SURGE_CYC(SU), .LOCK_CYC(LO)) uut (
    .ref_clk_in(clk), .reset_in(rst), .variable_undervoltage_lockout_in(uv),
    .current_limit_in(cl), .secondary_current_limit_in(sc), .thermal_shutdown_in(th),
    .switch_enable_out(sw), .secondary_limit_select_out(sel), .secondary_clamp_out(clmp),
    .surge_active_out(sa), .lockout_active_out(lk), .uv_disengaged_out(dis));
  pwsft_load_model u_load (.ref_clk_in(clk), .switch_enable_in(sw), .overload_in(ovl),
    .short_in(sht), .current_limit_out(cl), .secondary_limit_out(sc));
  task automatic chk(string nm, logic e, logic g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Waits for an output to reach a level and judges the delay, bounded so a hang cannot stall.
  task automatic wt(int k, logic v, int lo, int hi);
    int n;
    n = 0;
    while ((k == 0 ? sw : k == 1 ? sel : lk) !== v && n <= hi)
    begin
      @(negedge clk);
      n++;
    end
    chk("delay in window", 1'h1, n >= lo && n <= hi);
  endtask
  task automatic t_uv;
    // A one-cycle rise above trip must restart the blanking count from zero.
    uv <= 1'h1;
    repeat (BL - 5) @(negedge clk);
    uv <= 1'h0;
    @(negedge clk);
    uv <= 1'h1;
    wt(0, 1'h0, BL - 2, BL + 4);
    chk("disengaged", 1'h1, dis);
    wt(0, 1'h1, OF - 2, OF + 4);
    chk("disengaged", 1'h0, dis);
    wt(0, 1'h0, BL - 2, BL + 4);
    uv <= 1'h0;
    wt(0, 1'h1, OF - 2, OF + 4);
    repeat (BL * 2) @(negedge clk);
    chk("switch", 1'h1, sw);
  endtask
  task automatic t_surge;
    ovl <= 1'h1;
    wt(1, 1'h1, 1, 4);
    chk("surge", 1'h1, sa);
    sht <= 1'h1;
    wt(1, 1'h0, SU - 4, SU + 3);
    chk("surge", 1'h0, sa);
    chk("clamp", 1'h1, clmp);
    sht <= 1'h0;
    repeat (20) @(negedge clk);
    chk("select", 1'h0, sel);
    ovl <= 1'h0;
    wt(2, 1'h1, 1, 4);
    ovl <= 1'h1;
    repeat (5) @(negedge clk);
    chk("select", 1'h0, sel);
    ovl <= 1'h0;
    wt(2, 1'h1, 1, 4);
    wt(2, 1'h0, LO - 2, LO + 4);
    ovl <= 1'h1;
    wt(1, 1'h1, 1, 4);
    th <= 1'h1;
    repeat (2) @(negedge clk);
    chk("switch", 1'h0, sw);
    chk("select", 1'h0, sel);
    chk("disengaged", 1'h0, dis);
    th <= 1'h0;
    repeat (4) @(negedge clk);
    chk("switch", 1'h1, sw);
    chk("select", 1'h0, sel);
    ovl <= 1'h0;
    repeat (LO + 10) @(negedge clk);
  endtask
  task automatic t_indep;
    ovl <= 1'h1;
    wt(1, 1'h1, 1, 4);
    uv <= 1'h1;
    wt(0, 1'h0, BL - 2, BL + 4);
    chk("select", 1'h1, sel);
    uv <= 1'h0;
    ovl <= 1'h0;
    repeat (OF + LO + 10) @(negedge clk);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  initial
  begin
    repeat (5) @(negedge clk);
    chk("switch", 1'h0, sw);
    rst <= 1'h0;
    repeat (3) @(negedge clk);
    chk("switch", 1'h0, sw);
    chk("disengaged", 1'h1, dis);
    uv <= 1'h0;
    wt(0, 1'h1, 1, 4);
    t_uv;
    t_surge;
    t_indep;
    close_out;
  end
endmodule
bind pwsft_top pwsft_monitor #(.BLANK_CYC(BLANK_CYC)) u_mon (.ref_clk_in(ref_clk_in),
  .reset_in(reset_in), .variable_undervoltage_lockout_in(variable_undervoltage_lockout_in),
  .current_limit_in(current_limit_in), .secondary_current_limit_in(secondary_current_limit_in),
  .thermal_shutdown_in(thermal_shutdown_in), .switch_enable_out(switch_enable_out),
  .secondary_limit_select_out(secondary_limit_select_out),
  .secondary_clamp_out(secondary_clamp_out), .surge_active_out(surge_active_out),
  .lockout_active_out(lockout_active_out), .uv_disengaged_out(uv_disengaged_out));
